// [rtl/sch_top.sv]
// Two independent monitoring memories: sample capture or bin histogram.
// Assumes tap samples and processor strobes are synchronous to clk.
//
// Notes on behaviour
// - Two identical monitors, A and B, configured and run independently.
// - Each monitor is off, capturing, or accumulating a histogram.
// - Capture uses 2048 sixteen-bit words, I and Q interleaved.
// - Bin n counter: upper half at address 2n, lower half at 2n+1.
// - Source tap: datapath input or output of cancel stage 1 to 4.
// - Capture stores sample bits 17..2; I at 2n, Q at 2n+1.
// - Histogram function is I, Q, or I*I+Q*Q.
// - Magnitude squared drops its low 16 bits.
// - Values outside inclusive low..high bounds are ignored.
// - In range: subtract low, multiply by scale, 10-bit index, bump bin.
// - Bounds are signed 16-bit; scale is a 16-bit multiplier.
// - Duration count is in units of 65536 samples.
// - A clear command zeroes every entry of that memory.
// - Pointer advances by one on every data port access.
// - Pointer past the top address wraps to zero.
`timescale 1ns/1ps
`default_nettype none

module sch_top
(
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    ce,
  input  wire logic [4:0][17:0]        tap_i,
  input  wire logic [4:0][17:0]        tap_q,
  input  wire logic                    sample_valid,
  input  wire logic [1:0][1:0]         monitor_mode,
  input  wire logic [1:0][2:0]         monitor_tap,
  input  wire logic [1:0][1:0]         monitor_func,
  input  wire logic [1:0][15:0]        hist_range_low,
  input  wire logic [1:0][15:0]        hist_range_high,
  input  wire logic [1:0][15:0]        hist_index_scale,
  input  wire logic [1:0][15:0]        hist_duration_count,
  input  wire logic [1:0]              monitor_start,
  input  wire logic [1:0]              monitor_clear,
  input  wire logic [1:0]              monitor_pointer_load,
  input  wire logic [10:0]             monitor_pointer_wdata,
  input  wire logic [1:0]              monitor_data_read,
  output logic      [1:0][15:0]        monitor_data_port,
  output logic      [1:0][10:0]        monitor_pointer,
  output logic      [1:0]              monitor_busy,
  output logic      [1:0]              monitor_done
);

  // ----------------------------------------------------------------------
  // One monitor per loop pass
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < sch_pkg::SCH_MONITORS; g++)
    begin : g_mon
      sch_pkg::sch_mon_t s_r;
      sch_pkg::sch_mon_t s_nxt;
      // Each row holds one bin or one complex sample: upper word at the even
      // address, lower word at the odd address
      logic [31:0]       mem [0:sch_pkg::SCH_BINS-1];
      logic [17:0]       sel_i;
      logic [17:0]       sel_q;
      logic              hv;
      logic [9:0]        hidx;
      logic [31:0]       hist_old;
      logic [31:0]       rd_row;
      logic              we;
      logic [9:0]        wa;
      logic [31:0]       wd;
      logic              go;
      logic              take;

      // Tap selection; codes above the last stage fall back to the input
      always_comb
      begin
        if (s_r.tap <= sch_pkg::SCH_TAP_LAST)
        begin
          sel_i = tap_i[s_r.tap];
          sel_q = tap_q[s_r.tap];
        end
        else
        begin
          sel_i = tap_i[sch_pkg::SCH_TAP_INPUT];
          sel_q = tap_q[sch_pkg::SCH_TAP_INPUT];
        end
      end

      // Function generator and bin index, only fed while histogramming
      sch_hist_func u_func
      (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .in_valid  (take),
        .in_i      (sel_i),
        .in_q      (sel_q),
        .func      (s_r.func),
        .low       (s_r.low),
        .high      (s_r.high),
        .scale     (s_r.scale),
        .out_valid (hv),
        .out_index (hidx)
      );

      assign hist_old = mem[hidx];
      assign rd_row   = mem[s_r.ptr[10:1]];
      assign go       = monitor_start[g] &&
                        (monitor_mode[g] == sch_pkg::SCH_MODE_CAPT ||
                         monitor_mode[g] == sch_pkg::SCH_MODE_HIST);
      // Samples feed the histogram only until the duration count is reached,
      // so the final cycle in run state adds no extra count
      assign take     = sample_valid && s_r.st == sch_pkg::SCH_ST_RUN &&
                        s_r.mode == sch_pkg::SCH_MODE_HIST &&
                        s_r.samp != {s_r.dur, 16'h0};

      // Next state: pointer port, sequencing and memory write selection
      always_comb
      begin
        s_nxt = s_r;
        we    = 1'b0;
        wa    = hidx;
        wd    = hist_old + 32'h1;
        // Processor side uses its own read port only
        if (monitor_pointer_load[g])
          s_nxt.ptr = monitor_pointer_wdata;
        else if (monitor_data_read[g])
        begin
          s_nxt.rdata = s_r.ptr[0] ? rd_row[15:0] : rd_row[31:16];
          if (s_r.ptr == sch_pkg::SCH_ADDR_TOP)
            s_nxt.ptr = '0;
          else
            s_nxt.ptr = s_r.ptr + 11'h1;
        end
        unique case (s_r.st)
          sch_pkg::SCH_ST_IDLE,
          sch_pkg::SCH_ST_DONE:
          begin
            if (monitor_clear[g])
            begin
              s_nxt.st   = sch_pkg::SCH_ST_CLEAR;
              s_nxt.wcnt = '0;
            end
            else if (go)
            begin
              s_nxt.st    = sch_pkg::SCH_ST_RUN;
              s_nxt.mode  = sch_pkg::sch_mode_t'(monitor_mode[g]);
              s_nxt.tap   = monitor_tap[g];
              s_nxt.func  = sch_pkg::sch_func_t'(monitor_func[g]);
              s_nxt.low   = hist_range_low[g];
              s_nxt.high  = hist_range_high[g];
              s_nxt.scale = hist_index_scale[g];
              s_nxt.dur   = hist_duration_count[g];
              s_nxt.wcnt  = '0;
              s_nxt.samp  = '0;
            end
          end
          sch_pkg::SCH_ST_CLEAR:
          begin
            // Walk every row writing zero
            we = 1'b1;
            wa = s_r.wcnt;
            wd = '0;
            s_nxt.wcnt = s_r.wcnt + 10'h1;
            if (s_r.wcnt == sch_pkg::SCH_LAST_ROW)
              s_nxt.st = sch_pkg::SCH_ST_IDLE;
          end
          sch_pkg::SCH_ST_RUN:
          begin
            if (s_r.mode == sch_pkg::SCH_MODE_CAPT)
            begin
              if (sample_valid)
              begin
                we = 1'b1;
                wa = s_r.wcnt;
                wd = {sel_i[17:sch_pkg::SCH_SAMPLE_LSB],
                      sel_q[17:sch_pkg::SCH_SAMPLE_LSB]};
                s_nxt.wcnt = s_r.wcnt + 10'h1;
                if (s_r.wcnt == sch_pkg::SCH_LAST_ROW)
                  s_nxt.st = sch_pkg::SCH_ST_DONE;
              end
            end
            else
            begin
              // Sample count ends at duration times 65536
              if (s_r.samp == {s_r.dur, 16'h0})
                s_nxt.st = sch_pkg::SCH_ST_DONE;
              else if (sample_valid)
                s_nxt.samp = s_r.samp + 32'h1;
              we = hv;
            end
          end
        endcase
        // Late index from the last accepted sample still lands
        if (s_r.st != sch_pkg::SCH_ST_CLEAR && s_r.st != sch_pkg::SCH_ST_RUN && hv)
          we = 1'b1;
      end

      // State register
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          s_r <= sch_pkg::SCH_MON_RESET;
        else if (ce)
          s_r <= s_nxt;
      end

      // Memory write port; datapath and clear own it
      always_ff @(posedge clk)
      begin
        if (ce && we)
          mem[wa] <= wd;
      end

      assign monitor_data_port[g] = s_r.rdata;
      assign monitor_pointer[g]   = s_r.ptr;
      assign monitor_busy[g]      = (s_r.st == sch_pkg::SCH_ST_CLEAR) ||
                                    (s_r.st == sch_pkg::SCH_ST_RUN);
      assign monitor_done[g]      = (s_r.st == sch_pkg::SCH_ST_DONE);
    end
  endgenerate

endmodule

`default_nettype wire

// [include/sch_pkg.sv]
// Package for the two-memory snapshot capture and histogram monitor.
// Assumes one datapath clock; all users refer to names as sch_pkg::name.
`default_nettype none

package sch_pkg;

  // ----------------------------------------------------------------------
  // Sizes and layout
  // ----------------------------------------------------------------------
  localparam int unsigned   SCH_MONITORS   = 2;
  localparam int unsigned   SCH_TAPS       = 5;
  localparam int unsigned   SCH_SAMPLE_W   = 18;
  localparam int unsigned   SCH_WORD_W     = 16;
  localparam int unsigned   SCH_BINS       = 1024;
  localparam int unsigned   SCH_SAMPLE_LSB = 2;
  localparam logic [10:0]   SCH_ADDR_TOP   = 11'h7ff;
  localparam logic [9:0]    SCH_LAST_ROW   = 10'h3ff;
  localparam int unsigned   SCH_SCALE_FRAC = 15;
  localparam int unsigned   SCH_DUR_SHIFT  = 16;

  // ----------------------------------------------------------------------
  // Modes, functions, taps and states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SCH_MODE_OFF  = 2'b00,
    SCH_MODE_CAPT = 2'b01,
    SCH_MODE_HIST = 2'b10
  } sch_mode_t;

  typedef enum logic [1:0] {
    SCH_FUNC_I   = 2'b00,
    SCH_FUNC_Q   = 2'b01,
    SCH_FUNC_MAG = 2'b10
  } sch_func_t;

  localparam logic [2:0]    SCH_TAP_INPUT  = 3'h0;
  localparam logic [2:0]    SCH_TAP_LAST   = 3'h4;

  typedef enum logic [1:0] {
    SCH_ST_IDLE  = 2'b00,
    SCH_ST_CLEAR = 2'b01,
    SCH_ST_RUN   = 2'b10,
    SCH_ST_DONE  = 2'b11
  } sch_state_t;

  // ----------------------------------------------------------------------
  // State records
  // ----------------------------------------------------------------------
  typedef struct packed {
    sch_state_t  st;
    sch_mode_t   mode;
    logic [2:0]  tap;
    sch_func_t   func;
    logic [15:0] low;
    logic [15:0] high;
    logic [15:0] scale;
    logic [15:0] dur;
    logic [10:0] ptr;
    logic [9:0]  wcnt;
    logic [31:0] samp;
    logic [15:0] rdata;
  } sch_mon_t;

  typedef struct packed {
    logic        valid;
    logic [9:0]  index;
  } sch_hf_t;

  localparam sch_mon_t SCH_MON_RESET = '0;
  localparam sch_hf_t  SCH_HF_RESET  = '0;

endpackage

`default_nettype wire

// [rtl/sch_hist_func.sv]
// Histogram function generator, range check and bin index scaling.
// Assumes samples synchronous to clk; one registered stage of latency.
`timescale 1ns/1ps
`default_nettype none

module sch_hist_func
(
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               ce,
  input  wire logic               in_valid,
  input  wire logic [17:0]        in_i,
  input  wire logic [17:0]        in_q,
  input  wire sch_pkg::sch_func_t func,
  input  wire logic [15:0]        low,
  input  wire logic [15:0]        high,
  input  wire logic [15:0]        scale,
  output logic                    out_valid,
  output logic [9:0]              out_index
);

  sch_pkg::sch_hf_t      s_r;
  sch_pkg::sch_hf_t      s_nxt;
  logic signed [15:0]    si;
  logic signed [15:0]    sq;
  logic signed [31:0]    pi;
  logic signed [31:0]    pq;
  logic [31:0]           mag;
  logic signed [15:0]    f;
  logic [16:0]           diff;
  logic [31:0]           prod;

  // --------------------------------------------------------------------
  // Function value, range test and index
  // --------------------------------------------------------------------
  always_comb
  begin
    si    = in_i[17:2];
    sq    = in_q[17:2];
    pi    = si * si;
    pq    = sq * sq;
    mag   = unsigned'(pi) + unsigned'(pq);
    unique case (func)
      sch_pkg::SCH_FUNC_I:   f = si;
      sch_pkg::SCH_FUNC_Q:   f = sq;
      sch_pkg::SCH_FUNC_MAG: f = signed'(mag[31:16]);
      default:               f = si;
    endcase
    diff  = 17'({f[15], f} - {low[15], low});
    prod  = diff[15:0] * scale;
    s_nxt = s_r;
    s_nxt.valid = in_valid && (f >= signed'(low)) && (f <= signed'(high));
    s_nxt.index = prod[sch_pkg::SCH_SCALE_FRAC +: 10];
  end

  // Pipeline register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s_r <= sch_pkg::SCH_HF_RESET;
    else if (ce)
      s_r <= s_nxt;
  end

  assign out_valid = s_r.valid;
  assign out_index = s_r.index;

endmodule

`default_nettype wire

// [testbench/sch_top_asserts.sv]
// Port checks for the monitor block, bound into sch_top.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
// ----
// Checker
// ----
module sch_top_asserts
(
  input wire logic             clk,
  input wire logic             rstn,
  input wire logic             ce,
  input wire logic             sample_valid,
  input wire logic [1:0][1:0]  monitor_mode,
  input wire logic [1:0]       monitor_start,
  input wire logic [1:0]       monitor_clear,
  input wire logic [1:0]       monitor_pointer_load,
  input wire logic [1:0]       monitor_data_read,
  input wire logic [1:0][10:0] monitor_pointer,
  input wire logic [1:0]       monitor_busy,
  input wire logic [1:0]       monitor_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic        clr_go, run_go, clr_on, cap_on, req_a;
  logic [1:0]  rd_go;
  logic [10:0] n_busy, n_val;
  // Accepted reads, clears and runs
  assign rd_go = {2{ce}} & monitor_data_read & ~monitor_pointer_load;
  assign req_a = ce && (monitor_clear[0] || monitor_start[0]);
  assign clr_go = ce && monitor_clear[0] && !monitor_busy[0];
  assign run_go = ce && monitor_start[0] && !monitor_clear[0] && !monitor_busy[0]
                  && monitor_mode[0] inside {2'b01, 2'b10};
  // Busy cycles and taken samples since the last accepted request on A
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      {clr_on, cap_on, n_busy, n_val} <= '0;
    else if (clr_go || run_go)
      {clr_on, cap_on, n_busy, n_val} <= {clr_go, run_go && monitor_mode[0] == 2'b01, 22'h0};
    else if (ce && monitor_busy[0])
      {n_busy, n_val} <= {11'(n_busy + 11'h1), 11'(n_val + 11'(sample_valid))};
  end
  AST_PTR_INC: assert property (rd_go[0]
    |=> monitor_pointer[0] == 11'($past(monitor_pointer[0]) + 11'h1))
    else $error("pointer A did not step");
  AST_PTR_B: assert property (rd_go[1]
    |=> monitor_pointer[1] == 11'($past(monitor_pointer[1]) + 11'h1))
    else $error("pointer B did not step");
  AST_PTR_HOLD: assert property (!(ce && (monitor_data_read[0] || monitor_pointer_load[0]))
    |=> $stable(monitor_pointer[0])) else $error("pointer A moved without access");
  AST_CLR_BUSY: assert property (clr_go |=> monitor_busy[0] && !monitor_done[0])
    else $error("clear not started");
  AST_CLR_LEN: assert property (clr_on && $fell(monitor_busy[0]) |-> n_busy == 11'd1024)
    else $error("clear length wrong");
  AST_CAP_LEN: assert property (cap_on && $rose(monitor_done[0])
    |-> n_val == 11'd1024) else $error("capture length wrong");
  AST_CAP_STOP: assert property (cap_on |-> n_val <= 11'd1024)
    else $error("capture ran on");
  AST_RUN_GO: assert property (run_go |=> monitor_busy[0])
    else $error("run not started");
  AST_ONE_STATE: assert property ($fell(monitor_done[0])
    |-> $past(req_a)) else $error("done dropped without a request");
endmodule
bind sch_top sch_top_asserts i_sch_top_asserts (.*);
`default_nettype wire

// [testbench/sch_dp_model.sv]
// Datapath source: random or fixed complex samples on all five taps.
// Assumes the bench clock; logs the samples taken while rec is high.
`timescale 1ns/1ps
`default_nettype none
// ----
// Source model
// ----
module sch_dp_model
(
  input  wire logic        clk,
  input  wire logic        fixed,
  input  wire logic [2:0]  sel,
  input  wire logic        rec,
  output logic [4:0][17:0] tap_i,
  output logic [4:0][17:0] tap_q,
  output logic             sample_valid
);
  logic [35:0] log_s[$];
  initial {tap_i, tap_q, sample_valid} = '0;
  // Log the taken sample, then present the next one, with random gaps unless fixed is high
  always @(posedge clk)
  begin
    if (rec && sample_valid)
      log_s.push_back({tap_i[sel], tap_q[sel]});
    #1;
    sample_valid = fixed || ($urandom_range(3) != 0);
    // Fixed sample: I bits 17..2 hold 5, Q bits 17..2 hold -3
    for (int k = 0; k < 5; k++)
      {tap_i[k], tap_q[k]} = fixed ? {18'h00014, 18'h3fff4} : 36'({$urandom, $urandom});
  end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the capture and histogram monitors.
// Assumes sch_top, its bound checker and the source model.
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench
// ----
module tb_top;
  logic             clk = 1'b0;
  logic             rstn, ce, sample_valid, fixed;
  logic [4:0][17:0] tap_i, tap_q;
  logic [1:0][1:0]  monitor_mode, monitor_func;
  logic [1:0][2:0]  monitor_tap;
  logic [1:0][15:0] hist_range_low, hist_range_high, hist_index_scale, hist_duration_count;
  logic [1:0]       monitor_start, monitor_clear, monitor_pointer_load, monitor_data_read;
  logic [10:0]      monitor_pointer_wdata, adr;
  logic [1:0][15:0] monitor_data_port;
  logic [1:0][10:0] monitor_pointer;
  logic [1:0]       monitor_busy, monitor_done;
  logic [35:0]      s;
  logic [16:0]      exp_q[$];
  int               failures = 0;
  int               tests_run = 0;
  always #2.5 clk = ~clk;
  sch_top i_sch_top (.*);
  sch_dp_model i_sch_dp_model (.clk(clk), .fixed(fixed), .sel(monitor_tap[0]),
    .rec(monitor_busy[0]), .tap_i(tap_i), .tap_q(tap_q), .sample_valid(sample_valid));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic m, input logic [15:0] e);
    exp_q.push_back({m, e});
    monitor_data_read[m] = 1'b1;
    tick(1);
  endtask
  task automatic ld(input logic m, input logic [10:0] a);
    monitor_data_read = '0;
    monitor_pointer_wdata = a;
    monitor_pointer_load[m] = 1'b1;
    tick(1);
    monitor_pointer_load = '0;
  endtask
  task automatic go(input logic [1:0] clr, input logic [1:0] st);
    {monitor_clear, monitor_start} = {clr, st};
    tick(1);
    {monitor_clear, monitor_start} = '0;
  endtask
  task automatic wait_for(input logic m, input logic dn);
    for (int k = 0; k < 70000 && (dn ? monitor_done[m] !== 1'b1 : monitor_busy[m] !== 1'b0); k++)
      tick(1);
    // A wait that runs out counts as a mismatch
    if (dn ? monitor_done[m] !== 1'b1 : monitor_busy[m] !== 1'b0)
      failures++;
  endtask
  task automatic end_sim;
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Checks each data word 2 ns after the clock edge that takes its read
  always @(posedge clk)
    if (|monitor_data_read)
    begin
      #2;
      cmp(monitor_data_port[exp_q[0][16]], exp_q[0][15:0]);
      void'(exp_q.pop_front());
    end
  // Cuts a hang short
  initial
  begin
    repeat (90000) @(posedge clk);
    failures++;
    end_sim();
  end
  // Main sequence: reset, off start, capture, wrap, histogram
  initial
  begin
    {rstn, ce, fixed, monitor_pointer_wdata} = 14'h1000;
    {monitor_mode, monitor_func, monitor_tap, monitor_start, monitor_clear} = '0;
    {monitor_pointer_load, monitor_data_read} = '0;
    {hist_range_low, hist_range_high, hist_index_scale, hist_duration_count} = '0;
    void'($urandom(32'hb25c));
    tick(12);
    rstn = 1'b1;
    tick(1);
    cmp({1'b0, monitor_pointer[0], monitor_busy, monitor_done}, 16'h0);
    go(2'b00, 2'b11);
    tick(1);
    cmp({14'h0, monitor_busy}, 16'h0);
    go(2'b01, 2'b00);
    wait_for(0, 0);
    monitor_tap[0] = 3'($urandom_range(4));
    monitor_mode[0] = 2'b01;
    i_sch_dp_model.log_s.delete();
    go(2'b00, 2'b01);
    wait_for(0, 1);
    cmp({14'h0, monitor_done}, 16'h1);
    ld(0, 11'h7ff);
    for (int a = 0; a < 2049; a++)
    begin
      adr = 11'(a + 2047);
      s = i_sch_dp_model.log_s[adr[10:1]];
      rd(0, adr[0] ? s[17:2] : s[35:20]);
    end
    monitor_data_read = '0;
    ce = 1'b0;
    tick(3);
    cmp({5'h0, monitor_pointer[0]}, 16'h0);
    ce = 1'b1;
    // Fixed samples: A counts Q in bin 6, B counts the squared magnitude in bin 0
    fixed = 1'b1;
    go(2'b11, 2'b00);
    wait_for(0, 0);
    wait_for(1, 0);
    {monitor_mode, monitor_func} = 8'ha9;
    monitor_tap[1] = 3'h3;
    hist_range_low = {16'h0000, 16'hfff0};
    hist_range_high = {16'h000a, 16'hfffd};
    hist_index_scale = {16'h0469, 16'h4000};
    hist_duration_count = {16'h0001, 16'h0001};
    go(2'b00, 2'b11);
    wait_for(1, 1);
    wait_for(0, 1);
    tick(4);
    ld(0, 11'h0);
    rd(0, 16'h0);
    rd(0, 16'h0);
    ld(0, 11'h00c);
    rd(0, 16'h0001);
    rd(0, 16'h0000);
    ld(1, 11'h0);
    rd(1, 16'h0001);
    rd(1, 16'h0000);
    rd(1, 16'h0000);
    monitor_data_read = '0;
    tick(3);
    end_sim();
  end
endmodule
`default_nettype wire
